// [carrier_extract.v]
/*
 * Receive carrier multiframe extractor: collects the 36 Fs bits of a
 * 72-frame multiframe, checks the 12-bit alignment, loads three message bytes.
 * Assumes fs_valid is a one-cycle strobe on sys_clk from the receive framer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_dl_defs.vh"

module carrier_extract (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       fs_valid,
	input  wire       fs_bit,
	output reg  [7:0] msg_one,
	output reg  [7:0] msg_two,
	output reg  [7:0] msg_three,
	output reg        msg_loaded
);

	reg  [35:0] fs_shift;    // newest Fs bit at the top
	reg  [5:0]  fs_count;    // Fs bits since last alignment
	reg         locked;      // alignment seen at the expected place
	wire [35:0] next_shift = {fs_bit, fs_shift[35:1]};
	wire        aligned    = (next_shift[11:0] == `CARRIER_ALIGN_PATTERN);

	// hunt, then check alignment once per multiframe
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_shift   <= 36'h0_0000_0000;
			fs_count   <= 6'h00;
			locked     <= 1'b0;
			msg_one    <= `RST_ZERO;
			msg_two    <= `RST_ZERO;
			msg_three  <= `RST_ZERO;
			msg_loaded <= 1'b0;
		end else begin
			msg_loaded <= 1'b0;
			if (!enable) begin
				// out of carrier mode: drop lock, keep the last message
				locked   <= 1'b0;
				fs_count <= 6'h00;
			end else if (fs_valid) begin
				fs_shift <= next_shift;
				if (aligned && (!locked || fs_count == `CARRIER_FS_LAST)) begin
					// 36 Fs bits in, pattern good: publish message RQ1
					msg_one    <= next_shift[19:12];
					msg_two    <= next_shift[27:20];
					msg_three  <= next_shift[35:28];
					msg_loaded <= 1'b1; // RQ3
					locked     <= 1'b1;
					fs_count   <= 6'h00;
				end else if (locked && fs_count == `CARRIER_FS_LAST) begin
					// pattern missing: no flag, go back to hunting RQ5
					locked   <= 1'b0;
					fs_count <= 6'h00;
				end else if (locked) begin
					fs_count <= fs_count + 6'h01;
				end
			end
		end
	end

endmodule // carrier_extract
`default_nettype wire

// [code_detector.v]
/*
 * Receive bit-oriented code detector: finds the ones-zero-code-zero word in
 * the data-link bits, filters repeats and times out absence.
 * Assumes bit_valid is a one-cycle strobe on sys_clk, LSB of code first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_dl_defs.vh"

module code_detector (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       bit_valid,
	input  wire       bit_in,
	input  wire [1:0] filter_sel,
	input  wire [1:0] disint_sel,
	output reg  [5:0] code,
	output reg        detect_pulse,
	output reg        clear_pulse
);

	reg  [15:0] word;        // oldest bit at the bottom
	reg  [5:0]  candidate;   // code being filtered
	reg  [2:0]  repeats;     // matching words in a row
	reg  [7:0]  gap;         // bits since last valid word
	reg         reported;    // a code is standing
	wire [15:0] next_word = {bit_in, word[15:1]};
	wire        match     = (next_word[7:0] == `CODE_ONES) && !next_word[8] && !next_word[15];
	wire [2:0]  need      = {filter_sel, 1'b1};   // 1, 3, 5 or 7 words
	wire [2:0]  next_rep  = (next_word[14:9] == candidate) ?
	                        ((repeats == 3'h7) ? repeats : repeats + 3'h1) : 3'h1;
	reg  [7:0]  gap_limit;

	// absence limit: 16, 32, 64 or 128 bits
	always @* begin
		case (disint_sel)
			2'h0:    gap_limit = 8'h10;
			2'h1:    gap_limit = 8'h20;
			2'h2:    gap_limit = 8'h40;
			default: gap_limit = 8'h80;
		endcase
	end

	// filter on entry, disintegrate on absence
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word         <= 16'h0000;
			candidate    <= 6'h00;
			repeats      <= 3'h0;
			gap          <= 8'h00;
			reported     <= 1'b0;
			code         <= 6'h00;
			detect_pulse <= 1'b0;
			clear_pulse  <= 1'b0;
		end else begin
			detect_pulse <= 1'b0;
			clear_pulse  <= 1'b0;
			if (!enable) begin
				// only ESF data-link bits are examined
				repeats  <= 3'h0;
				gap      <= 8'h00;
				reported <= 1'b0;
			end else if (bit_valid) begin
				word <= next_word;
				if (match) begin
					candidate <= next_word[14:9];
					repeats   <= next_rep;
					gap       <= 8'h00;
					// a new code, or the same code after a clear RQ13
					if (next_rep == need &&
					    (!reported || next_word[14:9] != code)) begin
						code         <= next_word[14:9];
						detect_pulse <= 1'b1; // RQ12
						reported     <= 1'b1;
					end
				end else if (gap != 8'hff) begin
					gap <= gap + 8'h01;
					if (reported && gap + 8'h01 == gap_limit) begin
						clear_pulse <= 1'b1; // RQ14
						reported    <= 1'b0;
						repeats     <= 3'h0;
					end
				end
			end
		end
	end

endmodule // code_detector
`default_nettype wire

// [t1_data_link_overhead.v]
/*
 * T1 data-link overhead for one framer: receive carrier message capture,
 * transmit code generator, receive code detector, byte-wide FDL serializer,
 * latched status, masks and active-low interrupt behind the register port.
 * Assumes framer strobes (rx_dl_valid, tx_slot) and mode levels come from
 * logic on sys_clk; register port is synchronous to sys_clk.
 */
// Notes on behaviour
// RQ1: carrier multiframe is 72 frames, 36 Fs
// RQ2: host configures D4, cross-couple, synchronizer, sync time
// RQ3: carrier message load sets status bit three
// RQ4: host reads message registers within 9ms
// RQ5: no carrier flag without 12-bit alignment
// RQ6: code generate and detect only in T1
// RQ7: transmit code taken from bits zero to five
// RQ8: send-code bit starts, frames and repeats code
// RQ9: host keeps F-bit pass-through at zero
// RQ10: host writes code before setting send bit
// RQ11: detection watches ESF data-link bits only
// RQ12: filtered code sets detect flag, shows code
// RQ13: detect flag stays clear until new code
// RQ14: absence beyond disintegration time sets clear flag
// RQ15: detect and clear flags drive interrupt when unmasked
// RQ16: register source feeds FDL or Fs bits
// RQ17: new FDL byte sent LSB first
// RQ18: empty flag after eight bits, masked interrupt
// RQ19: host has 2ms; else byte repeats
// RQ20: no zero insertion on FDL register data
// RQ21: host loads 1Ch, source select zero
// RQ22: D4 uses only lower six bits
// RQ23: latched flags clear by writing one
// RQ24: interrupt holds while any unmasked flag set
`timescale 1ns/1ps
`default_nettype none
`include "t1_dl_defs.vh"

module t1_data_link_overhead (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire [8:0] addr,
	input  wire       wr_en,
	input  wire       rd_en,
	input  wire [7:0] wr_data,
	output reg  [7:0] rd_data,
	input  wire       t1_mode,
	input  wire       esf_mode,
	input  wire       carrier_sync_enable,
	input  wire       rx_dl_valid,
	input  wire       rx_dl_bit,
	input  wire       tx_slot,
	output reg        tx_overhead_bit,
	output reg        tx_overhead_insert,
	output reg        irq_out_n
);

	// host-written registers
	reg  [7:0] rx_code_control;         // disintegration select in bits 1:0
	reg  [1:0] code_filter_sel;         // filter select, high bits of code value
	reg  [7:0] rx_interrupt_mask_seven; // masks for receive latched status
	reg  [7:0] tx_link_control_two;     // send-code enable lives here
	reg  [7:0] tx_fdl_byte;             // legacy FDL byte
	reg  [7:0] tx_code_value;           // code to send
	reg  [7:0] tx_control_one;          // F-bit pass-through lives here
	reg  [7:0] tx_control_two;          // FDL source select lives here
	reg  [7:0] tx_interrupt_mask_two;   // mask for FDL empty

	// latched status, set by hardware, cleared by host
	reg  [7:0] rx_latched_status_seven;
	reg  [7:0] tx_latched_status_two;

	// receive side results
	wire [7:0] msg_one;
	wire [7:0] msg_two;
	wire [7:0] msg_three;
	wire       msg_loaded;
	wire [5:0] rx_code;
	wire       code_detect_pulse;
	wire       code_clear_pulse;

	// transmit serializer state
	reg  [7:0] fdl_shift;     // byte on its way out
	reg  [3:0] fdl_index;     // bit position within the byte
	reg        fdl_empty_set; // one-cycle event, last bit gone
	reg  [3:0] code_index;    // bit position within the code word
	reg        code_running;  // generator owns the slots

	// decoded controls
	wire send_code_enable   = tx_link_control_two[`BIT_SEND_CODE];
	wire fbit_pass_through  = tx_control_one[`BIT_FBIT_PASS];
	wire fdl_from_register  = !tx_control_two[`BIT_FDL_SOURCE];
	wire rx_d4_framing      = !esf_mode;
	wire code_allowed_tx    = t1_mode && esf_mode;          // RQ6
	wire code_allowed_rx    = t1_mode && esf_mode;          // RQ6 RQ11
	wire carrier_allowed    = t1_mode && rx_d4_framing && carrier_sync_enable;
	wire [3:0] fdl_last     = esf_mode ? `FDL_LAST_ESF : `FDL_LAST_D4;
	wire [15:0] code_word   = {1'b0, tx_code_value[5:0], 1'b0, `CODE_ONES}; // RQ7

	// write strobes per register
	wire wr_rx_code_control = wr_en && addr == `ADDR_RX_CODE_CONTROL;
	wire wr_rx_code_value   = wr_en && addr == `ADDR_RX_CODE_VALUE;
	wire wr_rx_ls_seven     = wr_en && addr == `ADDR_RX_LS_SEVEN;
	wire wr_rx_im_seven     = wr_en && addr == `ADDR_RX_IM_SEVEN;
	wire wr_tx_link_two     = wr_en && addr == `ADDR_TX_LINK_CTL_TWO;
	wire wr_tx_fdl_byte     = wr_en && addr == `ADDR_TX_FDL_BYTE;
	wire wr_tx_code_value   = wr_en && addr == `ADDR_TX_CODE_VALUE;
	wire wr_tx_ctl_one      = wr_en && addr == `ADDR_TX_CTL_ONE;
	wire wr_tx_ctl_two      = wr_en && addr == `ADDR_TX_CTL_TWO;
	wire wr_tx_ls_two       = wr_en && addr == `ADDR_TX_LS_TWO;
	wire wr_tx_im_two       = wr_en && addr == `ADDR_TX_IM_TWO;

	// hardware set events gathered into status-shaped vectors
	wire [7:0] rx_set = {4'h0, msg_loaded, 1'b0, code_clear_pulse, code_detect_pulse};
	wire [7:0] tx_set = {3'h0, fdl_empty_set, 4'h0};

	// receive carrier message capture
	carrier_extract u_carrier (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.enable     (carrier_allowed),
		.fs_valid   (rx_dl_valid),
		.fs_bit     (rx_dl_bit),
		.msg_one    (msg_one),
		.msg_two    (msg_two),
		.msg_three  (msg_three),
		.msg_loaded (msg_loaded)
	);

	// receive code detector on the data-link bits
	code_detector u_detect (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.enable       (code_allowed_rx),
		.bit_valid    (rx_dl_valid),
		.bit_in       (rx_dl_bit),
		.filter_sel   (code_filter_sel),
		.disint_sel   (rx_code_control[1:0]),
		.code         (rx_code),
		.detect_pulse (code_detect_pulse),
		.clear_pulse  (code_clear_pulse)
	);

	// plain read-write control registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_code_control         <= `RST_ZERO;
			code_filter_sel         <= 2'h0;
			rx_interrupt_mask_seven <= `RST_ZERO;
			tx_link_control_two     <= `RST_ZERO;
			tx_fdl_byte             <= `RST_TX_FDL;
			tx_code_value           <= `RST_ZERO;
			tx_control_one          <= `RST_ZERO;
			tx_control_two          <= `RST_ZERO;
			tx_interrupt_mask_two   <= `RST_ZERO;
		end else begin
			if (wr_rx_code_control)
				rx_code_control <= wr_data;
			// code bits are read-only, only the filter bits take a write
			if (wr_rx_code_value)
				code_filter_sel <= {wr_data[`BIT_FILTER_HI], wr_data[`BIT_FILTER_LO]};
			if (wr_rx_im_seven)
				rx_interrupt_mask_seven <= wr_data;
			if (wr_tx_link_two)
				tx_link_control_two <= wr_data;
			if (wr_tx_fdl_byte)
				tx_fdl_byte <= wr_data;
			if (wr_tx_code_value)
				tx_code_value <= wr_data;
			if (wr_tx_ctl_one)
				tx_control_one <= wr_data;
			if (wr_tx_ctl_two)
				tx_control_two <= wr_data;
			if (wr_tx_im_two)
				tx_interrupt_mask_two <= wr_data;
		end
	end

	// latched status: write one clears, a same-cycle event wins
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_latched_status_seven <= `RST_ZERO;
			tx_latched_status_two   <= `RST_ZERO;
		end else begin
			rx_latched_status_seven <= (rx_latched_status_seven
			                           & ~(wr_rx_ls_seven ? wr_data : 8'h00))
			                           | rx_set; // RQ3 RQ12 RQ14 RQ23
			tx_latched_status_two   <= (tx_latched_status_two
			                           & ~(wr_tx_ls_two ? wr_data : 8'h00))
			                           | tx_set; // RQ18 RQ23
		end
	end

	// registered read port, unmapped offsets read zero
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `RST_ZERO;
		end else if (rd_en) begin
			case (addr)
				`ADDR_RX_CODE_CONTROL: rd_data <= rx_code_control;
				`ADDR_RX_CODE_VALUE:   rd_data <= {code_filter_sel, rx_code}; // RQ12
				`ADDR_RX_MSG_ONE:      rd_data <= msg_one;
				`ADDR_RX_MSG_TWO:      rd_data <= msg_two;
				`ADDR_RX_MSG_THREE:    rd_data <= msg_three;
				`ADDR_RX_LS_SEVEN:     rd_data <= rx_latched_status_seven;
				`ADDR_RX_IM_SEVEN:     rd_data <= rx_interrupt_mask_seven;
				`ADDR_TX_LINK_CTL_TWO: rd_data <= tx_link_control_two;
				`ADDR_TX_FDL_BYTE:     rd_data <= tx_fdl_byte;
				`ADDR_TX_CODE_VALUE:   rd_data <= tx_code_value;
				`ADDR_TX_CTL_ONE:      rd_data <= tx_control_one;
				`ADDR_TX_CTL_TWO:      rd_data <= tx_control_two;
				`ADDR_TX_LS_TWO:       rd_data <= tx_latched_status_two;
				`ADDR_TX_IM_TWO:       rd_data <= tx_interrupt_mask_two;
				default:               rd_data <= `RST_ZERO;
			endcase
		end
	end

	// code generator: ones run, zero, code, zero, over and over
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_index   <= 4'h0;
			code_running <= 1'b0;
		end else if (!(send_code_enable && code_allowed_tx)) begin
			// dropping the enable ends the word at once; next start is clean
			code_index   <= 4'h0;
			code_running <= 1'b0;
		end else begin
			code_running <= 1'b1; // RQ8
			if (tx_slot)
				code_index <= (code_index == `CODE_WORD_LAST) ? 4'h0 : code_index + 4'h1;
		end
	end

	// legacy FDL serializer, byte repeats until a new one is written
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fdl_shift     <= `RST_TX_FDL;
			fdl_index     <= 4'h0;
			fdl_empty_set <= 1'b0;
		end else begin
			fdl_empty_set <= 1'b0;
			// the serializer pauses while the code generator owns the slots
			if (tx_slot && t1_mode && fdl_from_register && !code_running) begin
				if (fdl_index >= fdl_last) begin
					// byte done: flag empty and reload, old or new RQ18 RQ19
					fdl_empty_set <= 1'b1;
					fdl_shift     <= tx_fdl_byte; // RQ17
					fdl_index     <= 4'h0;
				end else begin
					// raw shift, no zero insertion RQ20
					fdl_shift <= {1'b0, fdl_shift[7:1]};
					fdl_index <= fdl_index + 4'h1;
				end
			end
		end
	end

	// overhead bit toward the framer, code has priority over the byte
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_overhead_bit    <= 1'b0;
			tx_overhead_insert <= 1'b0;
		end else begin
			// pass-through leaves the sampled F-bit untouched
			tx_overhead_insert <= t1_mode && !fbit_pass_through &&
			                      (code_running || fdl_from_register); // RQ16
			if (tx_slot) begin
				if (code_running)
					tx_overhead_bit <= code_word[code_index]; // RQ8
				else
					tx_overhead_bit <= fdl_shift[0]; // RQ17 RQ22
			end
		end
	end

	// active-low interrupt, held while any unmasked flag stands
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			irq_out_n <= 1'b1;
		else
			irq_out_n <= !(|(rx_latched_status_seven & rx_interrupt_mask_seven) ||
			               |(tx_latched_status_two & tx_interrupt_mask_two)); // RQ15 RQ18 RQ24
	end

endmodule // t1_data_link_overhead
`default_nettype wire

// [t1_data_link_overhead_checker.sv]
/*
 * Port checker: slot inserts, output holds, interrupt masking.
 * Assumes it is bound into the design and shadows control writes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_dl_defs.vh"

module t1_dl_checker (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [8:0] addr,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic       t1_mode,
	input wire logic       esf_mode,
	input wire logic       tx_slot,
	input wire logic       tx_overhead_bit,
	input wire logic       tx_overhead_insert,
	input wire logic       irq_out_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic [7:0] ctl_one, ctl_two, link_two, rx_mask, tx_mask; // control shadows

	// shadows follow the design's register writes
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{ctl_one, ctl_two, link_two, rx_mask, tx_mask} <= '0;
		end else if (wr_en) begin
			case (addr)
			`ADDR_TX_CTL_ONE: ctl_one <= wr_data;
			`ADDR_TX_CTL_TWO: ctl_two <= wr_data;
			`ADDR_TX_LINK_CTL_TWO: link_two <= wr_data;
			`ADDR_RX_IM_SEVEN: rx_mask <= wr_data;
			`ADDR_TX_IM_TWO: tx_mask <= wr_data;
			default: ;
			endcase
		end
	end

	a_pass_through: assert property (tx_slot && ctl_one[6] |=> !tx_overhead_insert)
		else $error("insert under pass-through");
	a_t1_only: assert property (tx_slot && !t1_mode |=> !tx_overhead_insert)
		else $error("insert outside T1");
	a_reg_source: assert property (tx_slot && t1_mode && !ctl_one[6] && !ctl_two[7]
		|=> tx_overhead_insert) else $error("no register insert");
	a_no_source: assert property (tx_slot && ctl_two[7] && !$past(link_two[6])
		|=> !tx_overhead_insert) else $error("insert with no source");
	a_code_insert: assert property (tx_slot && t1_mode && esf_mode && link_two[6]
		&& !ctl_one[6] |=> ##1 tx_overhead_insert) else $error("code not inserted");
	a_bit_stands: assert property (!tx_slot |=> $stable(tx_overhead_bit))
		else $error("bit moved off slot");
	a_read_holds: assert property (!rd_en |=> $stable(rd_data))
		else $error("read data moved");
	a_irq_masked: assert property ((rx_mask == 8'h00 && tx_mask == 8'h00) [*2]
		|=> irq_out_n) else $error("irq with masks off");

	c_code_sent: cover property (tx_slot && link_two[6] && esf_mode);
	c_irq_low: cover property ($fell(irq_out_n));
	c_msg_read: cover property (rd_en && addr == `ADDR_RX_MSG_ONE);
endmodule // t1_dl_checker

bind t1_data_link_overhead t1_dl_checker u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
	.wr_data(wr_data), .rd_data(rd_data), .t1_mode(t1_mode), .esf_mode(esf_mode),
	.tx_slot(tx_slot), .tx_overhead_bit(tx_overhead_bit),
	.tx_overhead_insert(tx_overhead_insert), .irq_out_n(irq_out_n));

`default_nettype wire

// [t1_data_link_overhead_tb.sv]
/*
 * Bench: registers, FDL and code transmit, code detect, carrier capture.
 * Assumes t1_line_model as far side and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_dl_defs.vh"

module t1_data_link_overhead_tb;
	logic        sys_clk, rst_n, wr_en, rd_en; // clock, reset, strobes
	logic [8:0]  addr; // register offset
	logic [7:0]  wr_data, b, c; // write data, scratch
	logic [23:0] m; // carrier message
	logic        t1_mode, esf_mode, carrier_sync_enable;
	logic [3:0]  slot_gap; // far-side slot pacing
	wire  [7:0]  rd_data;
	wire         rx_dl_valid, rx_dl_bit, tx_slot, tx_overhead_bit, tx_overhead_insert, irq_out_n;
	logic [31:0] seed = 32'hd160; // xorshift state
	int          mismatches = 0, n_checks = 0;
	// mapped offsets plus one unmapped
	logic [8:0]  ra [15] = '{9'h015, 9'h063, 9'h064, 9'h065, 9'h066, 9'h096, 9'h0a6,
		9'h113, 9'h162, 9'h163, 9'h181, 9'h182, 9'h191, 9'h1a1, 9'h1ff};

	t1_data_link_overhead u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
		.wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
		.t1_mode(t1_mode), .esf_mode(esf_mode), .carrier_sync_enable(carrier_sync_enable),
		.rx_dl_valid(rx_dl_valid), .rx_dl_bit(rx_dl_bit), .tx_slot(tx_slot),
		.tx_overhead_bit(tx_overhead_bit), .tx_overhead_insert(tx_overhead_insert),
		.irq_out_n(irq_out_n));
	t1_line_model u_line (.sys_clk(sys_clk), .rst_n(rst_n), .slot_gap(slot_gap),
		.tx_overhead_bit(tx_overhead_bit), .tx_overhead_insert(tx_overhead_insert),
		.rx_dl_valid(rx_dl_valid), .rx_dl_bit(rx_dl_bit), .tx_slot(tx_slot));

	// 25 MHz
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// code word, bit 0 travels first
	function automatic logic [15:0] cword(input logic [5:0] k);
		return {1'b0, k, 1'b0, 8'hff};
	endfunction

	task automatic end_of_test();
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bail();
		mismatches++;
		end_of_test();
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// trailing idle cycle between strobes
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		cyc(1);
		wr_en = 1'b0;
		cyc(1);
	endtask
	task automatic rchk(input logic [8:0] a, input logic [7:0] msk, input logic [7:0] e);
		addr = a;
		rd_en = 1'b1;
		cyc(1);
		rd_en = 1'b0;
		cyc(1);
		chk(rd_data & msk, e);
	endtask
	task automatic push(input logic [15:0] w, input int n);
		for (int i = 0; i < n; i++)
			u_line.rq.push_back(w[i % 16]);
	endtask
	task automatic mf(input logic [15:0] al);
		push(al, 12);
		push(m[15:0], 16);
		push(16'(m[23:16]), 8);
	endtask
	// tail covers flag latency
	task automatic drain();
		for (int i = 0; i < 3000 && u_line.rq.size() > 0; i++)
			cyc(1);
		if (u_line.rq.size() > 0)
			bail();
		cyc(4);
	endtask
	// clear empty flag, poll to next byte end
	task automatic wait_empty();
		int i;
		wr(`ADDR_TX_LS_TWO, 8'h10);
		for (i = 0; i < 300; i++) begin
			addr = `ADDR_TX_LS_TWO;
			rd_en = 1'b1;
			cyc(1);
			rd_en = 1'b0;
			cyc(1);
			if (rd_data[4] === 1'b1)
				break;
		end
		if (i == 300)
			bail();
	endtask
	task automatic cmp_tq(input logic [31:0] w, input int n);
		chk(u_line.tq.size(), n);
		for (int i = 0; i < n && i < u_line.tq.size(); i++)
			chk(u_line.tq[i], w[i]);
		u_line.tq.delete();
	endtask

	// hang guard
	initial begin
		repeat (90000) @(posedge sys_clk);
		bail();
	end

	initial begin
		{rst_n, wr_en, rd_en, addr, wr_data} = '0;
		{t1_mode, esf_mode, carrier_sync_enable} = 3'b100;
		slot_gap = 4'h8;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		foreach (ra[i])
			rchk(ra[i], 8'hff, ra[i] == `ADDR_TX_FDL_BYTE ? 8'h1c : 8'h00);
		// random read-back outside T1
		t1_mode = 1'b0;
		foreach (ra[i]) if (i == 0 || i inside {[6:11], 13}) begin
			b = rnd();
			wr(ra[i], b);
			rchk(ra[i], 8'hff, b);
			wr(ra[i], 8'h00);
		end
		wr(`ADDR_RX_CODE_VALUE, 8'hff);
		rchk(`ADDR_RX_CODE_VALUE, 8'hff, 8'hc0);
		wr(`ADDR_TX_FDL_BYTE, 8'h1c);
		t1_mode = 1'b1;
		// D4: six bits, then the byte again
		b = rnd();
		wr(`ADDR_TX_FDL_BYTE, b);
		wait_empty();
		u_line.tq.delete();
		wait_empty();
		cmp_tq(b, 6);
		wait_empty();
		cmp_tq(b, 6);
		wr(`ADDR_TX_CTL_ONE, 8'h40);
		cyc(20);
		wr(`ADDR_TX_CTL_ONE, 8'h00);
		// source off: no empty event races the irq checks
		wr(`ADDR_TX_CTL_TWO, 8'h80);
		cyc(20);
		wr(`ADDR_TX_LS_TWO, 8'h00);
		rchk(`ADDR_TX_LS_TWO, 8'h10, 8'h10);
		wr(`ADDR_TX_IM_TWO, 8'h10);
		chk(irq_out_n, 1'b0);
		wr(`ADDR_TX_LS_TWO, 8'h10);
		chk(irq_out_n, 1'b1);
		wr(`ADDR_TX_IM_TWO, 8'h00);
		wr(`ADDR_TX_CTL_TWO, 8'h00);
		// ESF: eight bits, six ones unstuffed
		esf_mode = 1'b1;
		wr(`ADDR_TX_FDL_BYTE, 8'hbf);
		wait_empty();
		wait_empty();
		u_line.tq.delete();
		wait_empty();
		cmp_tq(8'hbf, 8);
		// start just after a slot: first bit is word bit 0
		c = rnd();
		wr(`ADDR_TX_CODE_VALUE, {2'b10, c[5:0]});
		for (int i = 0; i < 20 && tx_slot !== 1'b1; i++)
			cyc(1);
		cyc(3);
		wr(`ADDR_TX_LINK_CTL_TWO, 8'h40);
		u_line.tq.delete();
		for (int i = 0; i < 600 && u_line.tq.size() < 32; i++)
			cyc(1);
		cmp_tq({cword(c[5:0]), cword(c[5:0])}, 32);
		wr(`ADDR_TX_LINK_CTL_TWO, 8'h00);
		// every filter and disintegration setting
		wr(`ADDR_RX_IM_SEVEN, 8'h03);
		for (int s = 0; s < 4; s++) begin
			c = rnd();
			wr(`ADDR_RX_CODE_VALUE, 8'(s << 6));
			wr(`ADDR_RX_CODE_CONTROL, 8'(s));
			wr(`ADDR_RX_LS_SEVEN, 8'h0b);
			push(cword(c[5:0]), 32 * s);
			drain();
			rchk(`ADDR_RX_LS_SEVEN, 8'h01, 8'h00);
			push(cword(c[5:0]), 16);
			drain();
			rchk(`ADDR_RX_LS_SEVEN, 8'h03, 8'h01);
			rchk(`ADDR_RX_CODE_VALUE, 8'h3f, c[5:0]);
			chk(irq_out_n, 1'b0);
			wr(`ADDR_RX_LS_SEVEN, 8'h01);
			push(16'h0000, (16 << s) - 8);
			drain();
			rchk(`ADDR_RX_LS_SEVEN, 8'h03, 8'h00);
			push(16'h0000, 16);
			drain();
			rchk(`ADDR_RX_LS_SEVEN, 8'h03, 8'h02);
			wr(`ADDR_RX_LS_SEVEN, 8'h0b);
			chk(irq_out_n, 1'b1);
		end
		push(cword(c[5:0]), 112);
		drain();
		rchk(`ADDR_RX_LS_SEVEN, 8'h01, 8'h01);
		// D4, then outside T1: no detection
		for (int k = 0; k < 2; k++) begin
			{t1_mode, esf_mode} = k ? 2'b01 : 2'b10;
			wr(`ADDR_RX_LS_SEVEN, 8'h0b);
			push(cword(c[5:0]), 112);
			drain();
			rchk(`ADDR_RX_LS_SEVEN, 8'h01, 8'h00);
		end
		// carrier capture, then a broken alignment
		{t1_mode, esf_mode, carrier_sync_enable} = 3'b101;
		m = rnd();
		wr(`ADDR_RX_LS_SEVEN, 8'h0b);
		mf(16'h01c7);
		mf(16'h01c7);
		drain();
		rchk(`ADDR_RX_LS_SEVEN, 8'h08, 8'h08);
		rchk(`ADDR_RX_MSG_ONE, 8'hff, m[7:0]);
		rchk(`ADDR_RX_MSG_TWO, 8'hff, m[15:8]);
		rchk(`ADDR_RX_MSG_THREE, 8'hff, m[23:16]);
		wr(`ADDR_RX_LS_SEVEN, 8'h08);
		mf(16'h01c6);
		drain();
		rchk(`ADDR_RX_LS_SEVEN, 8'h08, 8'h00);
		end_of_test();
	end
endmodule // t1_data_link_overhead_tb

`default_nettype wire

// [t1_dl_defs.vh]
/*
 * Shared constants for the T1 data-link overhead block: register offsets,
 * bit positions, reset values and framing counts.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef T1_DL_DEFS_VH
`define T1_DL_DEFS_VH

// register offsets on the framer's 9-bit register port
`define ADDR_RX_CODE_CONTROL  9'h015
`define ADDR_RX_CODE_VALUE    9'h063
`define ADDR_RX_MSG_ONE       9'h064
`define ADDR_RX_MSG_TWO       9'h065
`define ADDR_RX_MSG_THREE     9'h066
`define ADDR_RX_LS_SEVEN      9'h096
`define ADDR_RX_IM_SEVEN      9'h0a6
`define ADDR_TX_LINK_CTL_TWO  9'h113
`define ADDR_TX_FDL_BYTE      9'h162
`define ADDR_TX_CODE_VALUE    9'h163
`define ADDR_TX_CTL_ONE       9'h181
`define ADDR_TX_CTL_TWO       9'h182
`define ADDR_TX_LS_TWO        9'h191
`define ADDR_TX_IM_TWO        9'h1a1

// bit positions
`define BIT_CODE_DETECT       0
`define BIT_CODE_CLEAR        1
`define BIT_CARRIER_MSG       3
`define BIT_FDL_EMPTY         4
`define BIT_SEND_CODE         6
`define BIT_FBIT_PASS         6
`define BIT_FDL_SOURCE        7
`define BIT_FILTER_LO         6
`define BIT_FILTER_HI         7

// reset values
`define RST_ZERO              8'h00
`define RST_TX_FDL            8'h1c

// carrier multiframe: 72 frames, 36 Fs bits, 12 of them alignment
`define CARRIER_FRAMES        72
`define CARRIER_FS_BITS       36
`define CARRIER_FS_LAST       6'h23
`define CARRIER_ALIGN_PATTERN 12'h1c7

// serializer lengths per framing mode
`define FDL_LAST_ESF          4'h7
`define FDL_LAST_D4           4'h5

// code word: eight ones, zero, six code bits, zero
`define CODE_ONES             8'hff
`define CODE_WORD_LAST        4'hf

`endif

// [t1_line_model.sv]
/*
 * Far-side framer model: receive bits, slot pacing, insert log.
 * Assumes the bench fills rq and empties tq.
 */
`timescale 1ns/1ps
`default_nettype none

module t1_line_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] slot_gap,
	input  wire logic       tx_overhead_bit,
	input  wire logic       tx_overhead_insert,
	output var  logic       rx_dl_valid,
	output var  logic       rx_dl_bit,
	output var  logic       tx_slot
);
	logic       rq [$]; // bits to deliver
	logic       tq [$]; // inserted bits
	logic [3:0] cnt = 4'h0; // slot pacing
	logic       taken = 1'b0; // slot last cycle

	initial begin
		rx_dl_valid = 1'b0;
		rx_dl_bit = 1'b0;
		tx_slot = 1'b0;
	end

	// runs after bench drives: no race
	always @(posedge sys_clk) begin
		#2;
		if (taken && tx_overhead_insert)
			tq.push_back(tx_overhead_bit);
		taken = tx_slot;
		tx_slot = 1'b0;
		rx_dl_valid = 1'b0;
		// idle line shows no stale bit
		rx_dl_bit = ~rx_dl_bit;
		if (rst_n) begin
			cnt = cnt + 4'h1;
			if (cnt >= slot_gap) begin
				cnt = 4'h0;
				tx_slot = 1'b1;
			end
			// odd counts only: idle cycle between bits
			if (rq.size() > 0 && cnt[0]) begin
				rx_dl_valid = 1'b1;
				rx_dl_bit = rq.pop_front();
			end
		end
	end
endmodule // t1_line_model

`default_nettype wire
